// >>> tcc_params.svh
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH

// Register byte addresses on the APB port.
`define TCC_A_PDATA   8'h00
`define TCC_A_PDIR    8'h04
`define TCC_A_IOSEL   8'h08
`define TCC_A_CTRL    8'h0C
`define TCC_A_SYSC    8'h10
`define TCC_A_FORCE   8'h14
`define TCC_A_CH3     8'h18
`define TCC_A_CNT     8'h1C
`define TCC_A_CHV0    8'h20
`define TCC_A_CHV1    8'h24
`define TCC_A_CHV2    8'h28
`define TCC_A_CHV3    8'h2C
`define TCC_A_STAT    8'h30
`define TCC_A_IEN     8'h34

// Field positions.
`define TCC_CTRL_OM   0
`define TCC_CTRL_OL   4
`define TCC_CTRL_RISE 8
`define TCC_CTRL_FALL 12
`define TCC_SC_EN     0
`define TCC_SC_CRST   1
`define TCC_SC_PR     2
`define TCC_CH3_MASK  0
`define TCC_CH3_DATA  8

// Reset values.
`define TCC_RST_NIB   4'h0
`define TCC_RST_CTRL  16'h0000
`define TCC_RST_SYSC  5'h00
`define TCC_RST_CNT   16'h0000

// Prescaler: select 0 divides by 1, any other code divides by 16.
`define TCC_DIV_SLOW  5'd16
`define TCC_PR_FAST   3'h0

`endif

// >>> tcc_pkg.sv
`default_nettype none
package tcc_pkg;

   // One APB request as the master drives it.
   typedef struct packed {
      logic        psel;    // Slave selected.
      logic        penable; // Access phase.
      logic        pwrite;  // Write when high.
      logic [7:0]  paddr;   // Byte address.
      logic [31:0] pwdata;  // Write data.
   } tcc_apb_req_t;

   // The answer of the slave.
   typedef struct packed {
      logic        pready;  // Transfer completes.
      logic        pslverr; // Unmapped address.
      logic [31:0] prdata;  // Read data.
   } tcc_apb_rsp_t;

   // The four timer pins as driven by the block.
   typedef struct packed {
      logic [3:0] level;    // Driven level.
      logic [3:0] enable;   // Output enable, high while driven.
   } tcc_pin_drv_t;

endpackage
`default_nettype wire

// >>> tcc_timer.sv
// Behaviour
// (R1) Four buffered data bits drive general outputs.
// (R2) Data read: pin if input, latch if output.
// (R3) Data writes to compare pins only latch.
// (R4) Four direction bits, reset to all inputs.
// (R5) Software writes zero to reserved upper bits.
// (R6) One shared free-running 16-bit counter, four channels.
// (R7) Prescaler divides clock by 1 or 16.
// (R8) Capture channel copies counter on active edge.
// (R9) Capture pulses last over two clock periods.
// (R10) Capture only while pin direction is input.
// (R11) Event sets flag; interrupt needs enable bit.
// (R12) Compare match acts on pin, sets flag.
// (R13) Mode and level select set, clear, toggle.
// (R14) Force compare acts without setting the flag.
// (R15) Channel 3 compare overrides all other channels.
// (R16) Channel 3 compare loads masked data bits.
// (R17) Channel 3 compare may reset the counter.
// (R18) Compare drives pin whatever the direction bit.
// (R19) Event flags clear by writing one.
`timescale 1ns/100ps
`default_nettype none
`include "tcc_params.svh"

module tcc_timer (
   input  wire logic                  pclk,    // Module clock, 250 MHz.
   input  wire logic                  presetn, // Asynchronous reset, low.
   input  wire logic                  clk_en,  // Freezes all state when low.
   input  wire tcc_pkg::tcc_apb_req_t apb_req, // APB request.
   output var  tcc_pkg::tcc_apb_rsp_t apb_rsp, // APB answer.
   input  wire logic [3:0]            pin_in,  // Pin levels from outside.
   output var  tcc_pkg::tcc_pin_drv_t pin_drv, // Pin drive and enable.
   output var  logic                  irq      // Level interrupt request.
);
   import tcc_pkg::*;

   logic [3:0]  pin_data_q;      // Port data latch.
   logic [3:0]  pin_dir_q;       // Direction bits, 1 is output.
   logic [3:0]  io_sel_q;        // 1 selects output compare.
   logic [15:0] ctrl_q;          // Modes, levels and capture edges.
   logic [4:0]  sysc_q;          // Enable, counter reset, prescale.
   logic [3:0]  ch3_mask_q;      // Channel 3 mask bits.
   logic [3:0]  ch3_data_q;      // Channel 3 data bits.
   logic [15:0] cnt_q;           // Shared counter.
   logic [15:0] chv_q [4];       // Channel value registers.
   logic [3:0]  flag_q;          // Channel event flags.
   logic [3:0]  ien_q;           // Channel interrupt enables.
   logic [3:0]  oc_q;            // Compare output levels.
   logic [3:0]  pre_q;           // Prescaler count.
   logic        step_q;          // Counter changed last cycle.
   logic [3:0]  sync1_q;         // First synchroniser stage.
   logic [3:0]  sync2_q;         // Second synchroniser stage.
   logic [3:0]  prev_q;          // Delayed copy for edge detection.
   logic        pready_q;        // Registered ready.
   logic        pslverr_q;       // Registered error.
   logic [31:0] prdata_q;        // Registered read data.
   logic        irq_q;           // Registered interrupt.
   logic [3:0]  drv_lvl_q;       // Registered pin level.
   logic [3:0]  drv_en_q;        // Registered pin enable.

   logic        wr_en;           // Write takes effect this edge.
   logic        setup;           // Setup phase of a transfer.
   logic [31:0] rd_d;            // Read data for the address.
   logic        err_d;           // Address is unmapped.
   logic        tmr_en;          // Timer enabled.
   logic        tick;            // Counter advances this cycle.
   logic [3:0]  rise;            // Rising edges seen.
   logic [3:0]  fall;            // Falling edges seen.
   logic [3:0]  cap_ev;          // Capture events.
   logic [3:0]  cmp_ev;          // Compare matches.
   logic [3:0]  force_ev;        // Forced compares.
   logic [3:0]  act;             // Compare actions to perform.
   logic        ch3_hit;         // Channel 3 compare action.
   logic [3:0]  oc_on;           // Compare logic owns the pin.
   logic [3:0]  flag_d;          // Next flags.
   logic [3:0]  pin_data_d;      // Next port data latch.
   logic [3:0]  lvl_d;           // Next pin level.
   logic [3:0]  en_d;            // Next pin enable.

   // Bus phase decode; a write lands on the edge that sees pready.
   assign setup = apb_req.psel & ~apb_req.penable;
   assign wr_en = apb_req.psel & apb_req.penable & pready_q
                  & apb_req.pwrite;

   // Timer enable and the shared counter tick.
   assign tmr_en = sysc_q[`TCC_SC_EN];
   assign tick   = tmr_en & (pre_q == 4'h0);

   // Edge detection reads only the second synchroniser stage.
   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;

   // Per-channel events.
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         // Capture needs an input pin and an enabled edge.
         cap_ev[n] = tmr_en & ~io_sel_q[n] & ~pin_dir_q[n] //R8 R10
                     & ((rise[n] & ctrl_q[`TCC_CTRL_RISE + n])
                     | (fall[n] & ctrl_q[`TCC_CTRL_FALL + n]));
         // A compare fires once when the counter reaches the value.
         cmp_ev[n] = tmr_en & io_sel_q[n] & step_q //R12
                     & (cnt_q == chv_q[n]);
         // A forced compare comes from a force register write.
         force_ev[n] = wr_en & (apb_req.paddr == `TCC_A_FORCE) //R14
                       & io_sel_q[n] & apb_req.pwdata[n];
         // Compare logic owns the pin of a compare channel while the timer is enabled, unless mode and level are zero.
         oc_on[n] = tmr_en & io_sel_q[n] //R13
                    & (ctrl_q[`TCC_CTRL_OM + n]
                    | ctrl_q[`TCC_CTRL_OL + n]);
      end
   end

   // Any action, real or forced, moves the compare outputs.
   // Channel 3 acting in a cycle silences the other channels then.
   assign act     = cmp_ev | force_ev;
   assign ch3_hit = act[3];

   // Flags: hardware set wins over a software clear in the same cycle.
   always_comb begin
      flag_d = flag_q;
      if (wr_en && apb_req.paddr == `TCC_A_STAT) begin
         flag_d = flag_q & ~apb_req.pwdata[3:0]; //R19
      end
      // Forced compares are left out, so they never set a flag.
      flag_d = flag_d | cap_ev | cmp_ev; //R11 R12
   end

   // Port data latch: channel 3 compare beats a bus write.
   always_comb begin
      pin_data_d = pin_data_q;
      if (wr_en && apb_req.paddr == `TCC_A_PDATA) begin
         // Only the low nibble is kept; reserved bits are dropped.
         pin_data_d = apb_req.pwdata[3:0]; //R1 R3 R5
      end
      if (ch3_hit) begin
         pin_data_d = (pin_data_d & ~ch3_mask_q) //R16
                      | (ch3_data_q & ch3_mask_q);
      end
   end

   // Pin drive: compare first, then direction bit, else released.
   always_comb begin
      for (int n = 0; n < 4; n++) begin
         if (oc_on[n]) begin
            lvl_d[n] = oc_q[n]; //R18
            en_d[n]  = 1'b1;
         end else if (pin_dir_q[n]) begin
            lvl_d[n] = pin_data_q[n]; //R1
            en_d[n]  = 1'b1;
         end else begin
            // Released pin: the outside world sets its level.
            lvl_d[n] = 1'b0;
            en_d[n]  = 1'b0;
         end
      end
   end

   // Read data mux; reserved bits read as zero.
   always_comb begin
      rd_d  = 32'h0000_0000;
      err_d = 1'b0;
      unique case (apb_req.paddr)
         `TCC_A_PDATA: begin
            // Inputs show the pin, outputs the latch.
            rd_d[3:0] = (pin_dir_q & pin_data_q) //R2
                        | (~pin_dir_q & sync2_q);
         end
         `TCC_A_PDIR:  rd_d[3:0]  = pin_dir_q; //R4
         `TCC_A_IOSEL: rd_d[3:0]  = io_sel_q;
         `TCC_A_CTRL:  rd_d[15:0] = ctrl_q;
         `TCC_A_SYSC:  rd_d[4:0]  = sysc_q;
         `TCC_A_FORCE: rd_d       = 32'h0000_0000;
         `TCC_A_CH3: begin
            rd_d[`TCC_CH3_MASK +: 4] = ch3_mask_q;
            rd_d[`TCC_CH3_DATA +: 4] = ch3_data_q;
         end
         `TCC_A_CNT:   rd_d[15:0] = cnt_q;
         `TCC_A_CHV0:  rd_d[15:0] = chv_q[0];
         `TCC_A_CHV1:  rd_d[15:0] = chv_q[1];
         `TCC_A_CHV2:  rd_d[15:0] = chv_q[2];
         `TCC_A_CHV3:  rd_d[15:0] = chv_q[3];
         `TCC_A_STAT:  rd_d[3:0]  = flag_q;
         `TCC_A_IEN:   rd_d[3:0]  = ien_q;
         default:      err_d      = 1'b1;
      endcase
   end

   // APB answer: ready rises in the access phase, one wait-free cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (clk_en) begin
         pready_q  <= setup;
         pslverr_q <= setup & err_d;
         // Read data is taken at the setup edge, so it stands with pready.
         if (setup && !apb_req.pwrite) begin
            prdata_q <= rd_d;
         end
      end
   end

   // Configuration registers written by software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_dir_q  <= `TCC_RST_NIB; //R4
         io_sel_q   <= `TCC_RST_NIB;
         ctrl_q     <= `TCC_RST_CTRL;
         sysc_q     <= `TCC_RST_SYSC;
         ch3_mask_q <= `TCC_RST_NIB;
         ch3_data_q <= `TCC_RST_NIB;
         ien_q      <= `TCC_RST_NIB;
      end else if (clk_en && wr_en) begin
         unique case (apb_req.paddr)
            `TCC_A_PDIR:  pin_dir_q <= apb_req.pwdata[3:0]; //R4 R5
            `TCC_A_IOSEL: io_sel_q  <= apb_req.pwdata[3:0];
            `TCC_A_CTRL:  ctrl_q    <= apb_req.pwdata[15:0];
            `TCC_A_SYSC:  sysc_q    <= apb_req.pwdata[4:0]; //R7
            `TCC_A_CH3: begin
               ch3_mask_q <= apb_req.pwdata[`TCC_CH3_MASK +: 4];
               ch3_data_q <= apb_req.pwdata[`TCC_CH3_DATA +: 4];
            end
            `TCC_A_IEN:   ien_q     <= apb_req.pwdata[3:0]; //R11
            default: begin
               // Other addresses are handled by their own processes.
            end
         endcase
      end
   end

   // Port data latch.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_data_q <= `TCC_RST_NIB;
      end else if (clk_en) begin
         pin_data_q <= pin_data_d; //R3 R16
      end
   end

   // Prescaler: select zero passes every clock, others divide by 16.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 4'h0;
      end else if (clk_en) begin
         // A disabled timer or a fast select holds the divider at zero.
         if (!tmr_en
             || sysc_q[`TCC_SC_PR +: 3] == `TCC_PR_FAST) begin
            pre_q <= 4'h0; //R7
         end else if (pre_q == 4'((`TCC_DIV_SLOW) - 5'd1)) begin
            pre_q <= 4'h0;
         end else begin
            pre_q <= pre_q + 4'h1; //R7
         end
      end
   end

   // Free-running counter, reset by channel 3 when enabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q  <= `TCC_RST_CNT;
         step_q <= 1'b0;
      end else if (clk_en) begin
         // The step flag lets a compare fire once per counter value.
         step_q <= tick;
         // A reset from channel 3 wins over a tick in the same cycle.
         if (cmp_ev[3] && sysc_q[`TCC_SC_CRST]) begin
            cnt_q <= `TCC_RST_CNT; //R17
         end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001; //R6
         end
      end
   end

   // Channel value registers; a capture wins over a bus write.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int n = 0; n < 4; n++) begin
            chv_q[n] <= 16'h0000;
         end
      end else if (clk_en) begin
         for (int n = 0; n < 4; n++) begin
            // Software may preload a value; a capture overwrites it.
            if (cap_ev[n]) begin
               chv_q[n] <= cnt_q; //R8
            end else if (wr_en && apb_req.paddr
                         == 8'(`TCC_A_CHV0 + 4 * n)) begin
               chv_q[n] <= apb_req.pwdata[15:0];
            end
         end
      end
   end

   // Compare output levels; channel 3 overrides the other channels.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oc_q <= `TCC_RST_NIB;
      end else if (clk_en) begin
         for (int n = 0; n < 4; n++) begin
            // Masked channel 3 data wins over any other action on the pin.
            if (ch3_hit && ch3_mask_q[n]) begin
               oc_q[n] <= ch3_data_q[n]; //R15 R16
            end else if (act[n] && (n == 3 || !ch3_hit)) begin
               // Mode and level: 01 toggle, 10 clear, 11 set.
               unique case ({ctrl_q[`TCC_CTRL_OM + n],
                             ctrl_q[`TCC_CTRL_OL + n]})
                  2'b01:   oc_q[n] <= ~oc_q[n]; //R13
                  2'b10:   oc_q[n] <= 1'b0; //R13
                  2'b11:   oc_q[n] <= 1'b1; //R13
                  default: oc_q[n] <= oc_q[n];
               endcase
            end
         end
      end
   end

   // Event flags.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= `TCC_RST_NIB;
      end else if (clk_en) begin
         flag_q <= flag_d; //R11 R19
      end
   end

   // Interrupt: high while an enabled flag is set.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         // Next flags are used so the line follows a set without delay.
         irq_q <= |(flag_d & ien_q); //R11
      end
   end

   // Pin input synchroniser and edge-detect delay stage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= `TCC_RST_NIB;
         sync2_q <= `TCC_RST_NIB;
         prev_q  <= `TCC_RST_NIB;
      end else if (clk_en) begin
         // Only the second stage feeds logic; the first may be metastable.
         sync1_q <= pin_in;
         sync2_q <= sync1_q; //R9
         prev_q  <= sync2_q;
      end
   end

   // Registered pin drive.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drv_lvl_q <= `TCC_RST_NIB;
         drv_en_q  <= `TCC_RST_NIB;
      end else if (clk_en) begin
         // Registering the drive keeps every pin output free of glitches.
         drv_lvl_q <= lvl_d;
         drv_en_q  <= en_d;
      end
   end

   // Outputs straight from flip-flops.
   // No logic sits between these registers and the ports.
   assign apb_rsp.pready  = pready_q;
   assign apb_rsp.pslverr = pslverr_q;
   assign apb_rsp.prdata  = prdata_q;
   assign pin_drv.level   = drv_lvl_q;
   assign pin_drv.enable  = drv_en_q;
   assign irq             = irq_q;

endmodule // tcc_timer

`default_nettype wire

// >>> tcc_timer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcc_params.svh"
// Port-level checks of the timer block; it sees only the top ports.
module tcc_timer_asserts (
   input wire logic                  pclk,    // Module clock.
   input wire logic                  presetn, // Reset, active low.
   input wire logic                  clk_en,  // Clock enable.
   input wire tcc_pkg::tcc_apb_req_t apb_req, // APB request.
   input wire tcc_pkg::tcc_apb_rsp_t apb_rsp, // APB answer.
   input wire logic [3:0]            pin_in,  // Pin levels.
   input wire tcc_pkg::tcc_pin_drv_t pin_drv, // Pin drive.
   input wire logic                  irq      // Interrupt.
);
   import tcc_pkg::*;
   logic setup;  // Setup cycle taken by the slave.
   logic rd_end; // A read completes.
   logic hole;   // Address maps to no register.
   assign setup = apb_req.psel && !apb_req.penable && clk_en;
   assign rd_end = apb_rsp.pready && !apb_req.pwrite;
   assign hole = (apb_req.paddr[1:0] != 2'h0) || (apb_req.paddr > 8'h34)
      || (apb_req.paddr > 8'h2C && apb_req.paddr < 8'h30);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_after_setup_a: assert property (setup |=> apb_rsp.pready)
      else $error("pready missing after setup");
   ready_in_access_a: assert property (apb_rsp.pready |->
      apb_req.psel && apb_req.penable) else $error("pready outside access");
   ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready longer than one cycle");
   err_on_hole_a: assert property (setup && hole |=> apb_rsp.pslverr)
      else $error("no pslverr on unmapped address");
   err_only_hole_a: assert property (setup && !hole |=> !apb_rsp.pslverr)
      else $error("pslverr on mapped address");
   hole_reads_zero_a: assert property (rd_end && apb_rsp.pslverr |->
      apb_rsp.prdata == 32'h0) else $error("unmapped read not zero");
   pin_reads_clean_a: assert property (rd_end && (apb_req.paddr ==
      `TCC_A_PDATA || apb_req.paddr == `TCC_A_PDIR) |->
      apb_rsp.prdata[31:4] == 28'h0) else $error("upper pin bits not zero");
   force_reads_zero_a: assert property (rd_end &&
      apb_req.paddr == `TCC_A_FORCE |-> apb_rsp.prdata == 32'h0)
      else $error("force register read not zero");
   dir_drives_pin_a: assert property (apb_rsp.pready &&
      apb_req.pwrite && apb_req.paddr == `TCC_A_PDIR &&
      apb_req.pwdata[3:0] == 4'hF |-> ##[1:3] pin_drv.enable == 4'hF)
      else $error("outputs not driven after direction write");
   quiet_after_reset_a: assert property ($rose(presetn) |->
      pin_drv == '0 && !irq) else $error("outputs active after reset");
   // Main scenarios reached.
   irq_seen_c: cover property ($rose(irq));
   hole_seen_c: cover property (apb_rsp.pslverr);
   drive_seen_c: cover property (pin_drv.enable != 4'h0);
endmodule // tcc_timer_asserts
bind tcc_timer tcc_timer_asserts u_chk (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_in(pin_in),
   .pin_drv(pin_drv), .irq(irq));
`default_nettype wire

// >>> tcc_pins.sv
`timescale 1ns/100ps
`default_nettype none
// Model of the outside world at the four timer pins.
module tcc_pins (
   input wire logic                  pclk,   // Module clock.
   input wire tcc_pkg::tcc_pin_drv_t drv,    // Block drive.
   output var logic [3:0]            pin_in  // Wire levels seen.
);
   import tcc_pkg::*;
   logic [3:0] ext_q; // Level driven from outside.
   initial ext_q = 4'h0;
   // A pin the block drives shows its level, else the outside level.
   assign pin_in = (drv.enable & drv.level) | (~drv.enable & ext_q);
   // Sets all outside levels just after an edge.
   task automatic set_lvl(input logic [3:0] v);
      @(posedge pclk);
      ext_q <= v;
   endtask
   // Pulses stay high four clocks, over the two-clock minimum.
   task automatic pulse(input int n);
      @(posedge pclk);
      ext_q[n] <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_q[n] <= 1'b0;
   endtask
endmodule // tcc_pins
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "tcc_params.svh"
module tb_top;
   import tcc_pkg::*;
   logic         pclk;     // Module clock.
   logic         presetn;  // Reset, active low.
   logic         clk_en;   // Clock enable, dropped once.
   tcc_apb_req_t req;      // APB request.
   tcc_apb_rsp_t rsp;      // APB answer.
   logic [3:0]   pin_in;   // Pin levels.
   tcc_pin_drv_t drv;      // Pin drive.
   logic         irq;      // Interrupt.
   int           failures; // Mismatches.
   int           compares; // Comparisons.
   logic [31:0]  seed;     // Random state.
   logic [31:0]  r;        // Last read data.
   logic [31:0]  a;        // Scratch value.
   logic [31:0]  b;        // Scratch value.
   logic         err;      // Last pslverr.
   tcc_timer uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .apb_req(req), .apb_rsp(rsp), .pin_in(pin_in), .pin_drv(drv),
      .irq(irq));
   tcc_pins pins (.pclk(pclk), .drv(drv), .pin_in(pin_in));
   always #2 pclk = ~pclk;
   // Random source for data, direction and pin levels.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] z4(input logic [3:0] x);
      return {28'h0, x};
   endfunction
   // Pin data read: latch where output, pin where input.
   function automatic logic [31:0] gpio_rd(input logic [3:0] dir,
      input logic [3:0] d, input logic [3:0] ext);
      return z4((dir & d) | (~dir & ext));
   endfunction
   // One APB transfer; the request holds until pready is seen.
   task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] d);
      int n;
      @(posedge pclk);
      req <= '{1'b1, 1'b0, w, ad, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      r = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d);
   endtask
   task automatic rd(input logic [7:0] ad);
      apb(1'b0, ad, 32'h0);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Waits, bounded, for the interrupt line.
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      repeat (2) @(posedge pclk);
   endtask
   task automatic stop_test();
      if (failures == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #200000;
      failures++;
      stop_test();
   end
   // Main sequence.
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      clk_en = 1'b1;
      req = '0;
      failures = 0;
      compares = 0;
      seed = 32'h60D6;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TCC_A_PDIR);
      chk(r, 32'h0);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         wr(`TCC_A_PDATA, z4(seed[3:0]));
         wr(`TCC_A_PDIR, z4(seed[7:4]));
         pins.set_lvl(seed[11:8]);
         repeat (4) @(posedge pclk);
         rd(`TCC_A_PDATA);
         chk(r, gpio_rd(seed[7:4], seed[3:0], seed[11:8]));
         chk(z4(drv.enable), z4(seed[7:4]));
         chk(z4(drv.level & drv.enable), z4(seed[3:0] & seed[7:4]));
      end
      rd(8'h40);
      chk({31'h0, err}, 32'h1);
      // Channel 0 sets on compare, channel 1 toggles, channel 2 captures.
      pins.set_lvl(4'h0);
      wr(`TCC_A_PDIR, 32'h0);
      wr(`TCC_A_PDATA, 32'h0);
      wr(`TCC_A_IOSEL, 32'h3);
      wr(`TCC_A_CTRL, 32'h0431);
      wr(`TCC_A_IEN, 32'h1);
      wr(`TCC_A_CHV0, 32'h40);
      wr(`TCC_A_SYSC, 32'h1);
      wait_irq();
      chk({31'h0, irq}, 32'h1);
      rd(`TCC_A_STAT);
      chk(r, 32'h1);
      chk(z4(drv.enable & drv.level & 4'h1), 32'h1);
      rd(`TCC_A_PDIR);
      chk(r, 32'h0);
      wr(`TCC_A_PDATA, 32'hE);
      wr(`TCC_A_FORCE, 32'h2);
      repeat (2) @(posedge pclk);
      chk(z4(drv.level & 4'h3), 32'h3);
      // Channel 1 to clear mode; channel 2 captures on both edges.
      wr(`TCC_A_CTRL, 32'h4413);
      wr(`TCC_A_FORCE, 32'h2);
      repeat (2) @(posedge pclk);
      chk(z4(drv.level & 4'h3), 32'h1);
      rd(`TCC_A_FORCE);
      chk(r, 32'h0);
      wr(`TCC_A_STAT, 32'h0);
      rd(`TCC_A_STAT);
      chk(r, 32'h1);
      wr(`TCC_A_STAT, 32'h1);
      rd(`TCC_A_STAT);
      chk(r, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rd(`TCC_A_CNT);
      a = r;
      pins.pulse(2);
      repeat (4) @(posedge pclk);
      rd(`TCC_A_CNT);
      b = r;
      rd(`TCC_A_CHV0 + 8'h08);
      chk({31'h0, r > a && r < b}, 32'h1);
      rd(`TCC_A_STAT);
      chk(r, 32'h4);
      chk({31'h0, irq}, 32'h0);
      wr(`TCC_A_STAT, 32'h4);
      wr(`TCC_A_PDIR, 32'h4);
      pins.pulse(2);
      repeat (6) @(posedge pclk);
      rd(`TCC_A_STAT);
      chk(r, 32'h0);
      // Back to plain outputs: the kept latch appears.
      wr(`TCC_A_IOSEL, 32'h0);
      wr(`TCC_A_PDIR, 32'hF);
      repeat (2) @(posedge pclk);
      chk(z4(drv.level), 32'hE);
      // Channel 3 and channel 0 hit the same value.
      wr(`TCC_A_CH3, 32'h0506);
      wr(`TCC_A_IOSEL, 32'h9);
      wr(`TCC_A_CTRL, 32'h0010);
      wr(`TCC_A_IEN, 32'h8);
      rd(`TCC_A_CNT);
      a = r + 32'h40;
      wr(`TCC_A_CHV0, a);
      wr(`TCC_A_CHV0 + 8'h0C, a);
      wr(`TCC_A_SYSC, 32'h3);
      b = {31'h0, drv.level[0]};
      wait_irq();
      chk({31'h0, drv.level[0]}, b);
      rd(`TCC_A_PDATA);
      chk(r, 32'hC);
      rd(`TCC_A_CNT);
      chk({31'h0, r < 32'h20}, 32'h1);
      rd(`TCC_A_STAT);
      chk(r & 32'h8, 32'h8);
      // Divide by 1, then by 16.
      for (int i = 0; i < 2; i++) begin
         wr(`TCC_A_SYSC, (i == 0) ? 32'h1 : 32'h5);
         rd(`TCC_A_CNT);
         a = r;
         repeat (160) @(posedge pclk);
         rd(`TCC_A_CNT);
         b = r - a;
         if (i == 0) chk({31'h0, b >= 160 && b <= 168}, 32'h1);
         else chk({31'h0, b >= 9 && b <= 12}, 32'h1);
      end
      // Clock enable low freezes the counter over a hundred edges.
      wr(`TCC_A_SYSC, 32'h1);
      rd(`TCC_A_CNT);
      a = r;
      @(posedge pclk);
      clk_en <= 1'b0;
      repeat (100) @(posedge pclk);
      clk_en <= 1'b1;
      rd(`TCC_A_CNT);
      chk(r - a, 32'h4);
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
